/* rptcfg_defines.vh */
// Register offsets, field positions, reset values and codes for the packet and clock settings bank.
`ifndef RPTCFG_DEFINES_VH
`define RPTCFG_DEFINES_VH

`define RPT_ADDR_W 8
`define RPT_DATA_W 8

`define RPT_OFF_SYNC0 8'h19
`define RPT_OFF_TXPAR 8'h1A
`define RPT_OFF_CLKOUT 8'h1B
`define RPT_OFF_PLOAD 8'h1C
`define RPT_OFF_NODE 8'h1D
`define RPT_OFF_LINKFMT 8'h20

`define RPT_RST_SYNC0 8'h00
`define RPT_RST_TXPAR 8'h7C
`define RPT_RST_CLKOUT 8'hBC
`define RPT_RST_PLOAD 8'h00
`define RPT_RST_NODE 8'h00
`define RPT_RST_LINKFMT 8'h00
`define RPT_READ_NONE 8'h00

`define RPT_TX_CUTOFF_HI 7
`define RPT_TX_CUTOFF_LO 4
`define RPT_TX_POWER_HI 3
`define RPT_TX_POWER_LO 1
`define RPT_TX_WR_MASK 8'hFE

`define RPT_CLK_EN_BIT 7
`define RPT_CLK_DIV_HI 6
`define RPT_CLK_DIV_LO 2
`define RPT_CLK_WR_MASK 8'hFC

`define RPT_PL_MANCH_BIT 7
`define RPT_PL_LEN_HI 6
`define RPT_PL_LEN_LO 0

`define RPT_LF_VARLEN_BIT 7
`define RPT_LF_FILT_HI 2
`define RPT_LF_FILT_LO 1
`define RPT_LF_WR_MASK 8'h86

`define RPT_FILT_OFF 2'h0
`define RPT_FILT_NODE 2'h1
`define RPT_FILT_NODE_ZERO 2'h2
`define RPT_FILT_NODE_ZERO_BCAST 2'h3
`define RPT_ADDR_ZERO 8'h00
`define RPT_ADDR_BCAST 8'hFF

`define RPT_DIV_PASS 5'h00
`define RPT_CUTOFF_REF_KHZ 200
`define RPT_CUTOFF_REF_XTAL_KHZ 12800
`define RPT_CUTOFF_STEPS 8

`endif

/* rptcfg_addr_filter.v */
// Received-address acceptance check against the node address and the filter mode.
module rptcfg_addr_filter (
    input wire [1:0] filterMode,
    input wire [7:0] nodeAddr,
    input wire [7:0] rxAddr,
    output reg accept
);
`include "rptcfg_defines.vh"

    always @* begin
        case (filterMode)
            `RPT_FILT_OFF: accept = 1'b1;
            `RPT_FILT_NODE: accept = (rxAddr == nodeAddr);
            `RPT_FILT_NODE_ZERO: begin
                accept = (rxAddr == nodeAddr) || (rxAddr == `RPT_ADDR_ZERO);
            end
            default: begin
                accept = (rxAddr == nodeAddr) || (rxAddr == `RPT_ADDR_ZERO)
                    || (rxAddr == `RPT_ADDR_BCAST);
            end
        endcase
    end

endmodule // rptcfg_addr_filter

/* rptcfg_clkout_div.v */
// Clock output divider: a level that toggles every N cycles, giving the clock rate over 2N.
module rptcfg_clkout_div #(
    parameter DIV_W = 5
) (
    input wire clock,
    input wire rst_n,
    input wire enable,
    input wire [DIV_W-1:0] divCode,
    output wire passThru,
    output reg clkLevel_q,
    output reg clkEdge_q
);
`include "rptcfg_defines.vh"

    reg [DIV_W-1:0] count_q;
    wire halfDone;

    // A zero code cannot be produced as a toggling level from the same clock, so the
    // pad multiplexer outside is told to route the crystal clock straight through.
    assign passThru = enable && (divCode == `RPT_DIV_PASS);
    assign halfDone = (count_q >= divCode - {{(DIV_W-1){1'b0}}, 1'b1});

    always @(posedge clock) begin
        if (!rst_n) begin
            count_q <= {DIV_W{1'b0}};
            clkLevel_q <= 1'b0;
            clkEdge_q <= 1'b0;
        end else if (!enable || passThru) begin
            // Disabled output stays low; the count restarts so a new code takes cleanly.
            count_q <= {DIV_W{1'b0}};
            clkLevel_q <= 1'b0;
            clkEdge_q <= 1'b0;
        end else if (halfDone) begin
            count_q <= {DIV_W{1'b0}};
            clkLevel_q <= ~clkLevel_q;
            clkEdge_q <= ~clkLevel_q;
        end else begin
            count_q <= count_q + {{(DIV_W-1){1'b0}}, 1'b1};
            clkEdge_q <= 1'b0;
        end
    end

endmodule // rptcfg_clkout_div

/* rptcfg_bank.v */
// Packet, transmit and clock output settings register bank with its derived controls.
//
// Chosen here: the address-and-strobe port.

// The header comes first because the parameter defaults below already use its names.
`include "rptcfg_defines.vh"

module rptcfg_bank #(
    parameter XTAL_KHZ = `RPT_CUTOFF_REF_XTAL_KHZ,
    parameter CUTOFF_W = 16
) (
    input wire clock,
    input wire rst_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData_q,
    input wire [7:0] rxAddr,
    input wire rxAddrValid,
    input wire [7:0] rxLength,
    input wire rxLengthValid,
    output wire [7:0] syncWordValue,
    output wire [3:0] txInterpCutoff,
    output reg [CUTOFF_W-1:0] txCutoffKhz_q,
    output wire [2:0] txPowerLevel,
    output wire clkoutEnable,
    output wire [4:0] clkoutDivider,
    output wire clkOutLevel,
    output wire clkOutRise,
    output wire clkOutPassThru,
    output wire manchesterEnable,
    output wire [6:0] payloadLength,
    output wire lengthFormatSelect,
    output reg txLengthFromReg_q,
    output reg [6:0] txLength_q,
    output wire [7:0] nodeLocalAddress,
    output wire [1:0] addressFilterMode,
    output reg rxAddrAccept_q,
    output reg rxAddrReject_q,
    output reg rxLengthAccept_q,
    output reg rxLengthReject_q
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    reg [7:0] syncByte0_q;
    reg [7:0] txParams_q;
    reg [7:0] clkOutCtl_q;
    reg [7:0] payloadCfg_q;
    reg [7:0] nodeAddr_q;
    reg [7:0] linkFormat_q;
    reg [7:0] rdData_d;
    wire addrOk;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Merge write data into a register keeping the bits outside the writable mask as they are.
    function [7:0] maskedWrite;
        input [7:0] oldValue;
        input [7:0] newValue;
        input [7:0] wrMask;
        begin
            maskedWrite = (oldValue & ~wrMask) | (newValue & wrMask);
        end
    endfunction

    // Cutoff in kHz: reference cutoff scaled by crystal ratio and by (code + 1) / 8.
    function [CUTOFF_W-1:0] cutoffKhz;
        input [3:0] code;
        reg [31:0] scaled;
        begin
            scaled = (`RPT_CUTOFF_REF_KHZ * XTAL_KHZ * ({28'h0000000, code} + 32'h00000001))
                / (`RPT_CUTOFF_REF_XTAL_KHZ * `RPT_CUTOFF_STEPS);
            cutoffKhz = scaled[CUTOFF_W-1:0];
        end
    endfunction

    // Receive length check: equality in fixed format, upper bound in variable format.
    function lengthAllowed;
        input varLen;
        input [7:0] rxLen;
        input [6:0] cfgLen;
        begin
            if (varLen) begin
                lengthAllowed = (rxLen <= {1'b0, cfgLen});
            end else begin
                lengthAllowed = (rxLen == {1'b0, cfgLen});
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register writes.

    always @(posedge clock) begin
        if (!rst_n) begin
            syncByte0_q <= `RPT_RST_SYNC0;
            txParams_q <= `RPT_RST_TXPAR;
            clkOutCtl_q <= `RPT_RST_CLKOUT;
            payloadCfg_q <= `RPT_RST_PLOAD;
            nodeAddr_q <= `RPT_RST_NODE;
            linkFormat_q <= `RPT_RST_LINKFMT;
        end else if (regWrite) begin
            if (regAddr == `RPT_OFF_SYNC0) begin
                syncByte0_q <= regWrData;
            end else if (regAddr == `RPT_OFF_TXPAR) begin
                // The reserved low bit is held at zero even if software breaks the convention.
                txParams_q <= maskedWrite(txParams_q, regWrData, `RPT_TX_WR_MASK);
            end else if (regAddr == `RPT_OFF_CLKOUT) begin
                clkOutCtl_q <= maskedWrite(clkOutCtl_q, regWrData, `RPT_CLK_WR_MASK);
            end else if (regAddr == `RPT_OFF_PLOAD) begin
                payloadCfg_q <= regWrData;
            end else if (regAddr == `RPT_OFF_NODE) begin
                nodeAddr_q <= regWrData;
            end else if (regAddr == `RPT_OFF_LINKFMT) begin
                linkFormat_q <= maskedWrite(linkFormat_q, regWrData, `RPT_LF_WR_MASK);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register reads; data stands in the cycle after the strobe only.

    always @* begin
        rdData_d = `RPT_READ_NONE;
        if (regAddr == `RPT_OFF_SYNC0) begin
            rdData_d = syncByte0_q;
        end else if (regAddr == `RPT_OFF_TXPAR) begin
            rdData_d = txParams_q;
        end else if (regAddr == `RPT_OFF_CLKOUT) begin
            rdData_d = clkOutCtl_q;
        end else if (regAddr == `RPT_OFF_PLOAD) begin
            rdData_d = payloadCfg_q;
        end else if (regAddr == `RPT_OFF_NODE) begin
            rdData_d = nodeAddr_q;
        end else if (regAddr == `RPT_OFF_LINKFMT) begin
            rdData_d = linkFormat_q;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            regRdData_q <= `RPT_READ_NONE;
        end else if (regRead) begin
            regRdData_q <= rdData_d;
        end else begin
            regRdData_q <= `RPT_READ_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Field outputs.

    assign syncWordValue = syncByte0_q;
    assign txInterpCutoff = txParams_q[`RPT_TX_CUTOFF_HI:`RPT_TX_CUTOFF_LO];
    assign txPowerLevel = txParams_q[`RPT_TX_POWER_HI:`RPT_TX_POWER_LO];
    assign clkoutEnable = clkOutCtl_q[`RPT_CLK_EN_BIT];
    assign clkoutDivider = clkOutCtl_q[`RPT_CLK_DIV_HI:`RPT_CLK_DIV_LO];
    assign manchesterEnable = payloadCfg_q[`RPT_PL_MANCH_BIT];
    assign payloadLength = payloadCfg_q[`RPT_PL_LEN_HI:`RPT_PL_LEN_LO];
    assign nodeLocalAddress = nodeAddr_q;
    assign lengthFormatSelect = linkFormat_q[`RPT_LF_VARLEN_BIT];
    assign addressFilterMode = linkFormat_q[`RPT_LF_FILT_HI:`RPT_LF_FILT_LO];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Derived transmit controls.

    always @(posedge clock) begin
        if (!rst_n) begin
            txCutoffKhz_q <= {CUTOFF_W{1'b0}};
            txLengthFromReg_q <= 1'b0;
            txLength_q <= 7'h00;
        end else begin
            txCutoffKhz_q <= cutoffKhz(txInterpCutoff);
            // In variable format the transmit length comes from the payload itself.
            txLengthFromReg_q <= ~lengthFormatSelect;
            if (lengthFormatSelect) begin
                txLength_q <= 7'h00;
            end else begin
                txLength_q <= payloadLength;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Clock output.

    rptcfg_clkout_div #(
        .DIV_W(5)
    ) uClkDiv (
        .clock(clock),
        .rst_n(rst_n),
        .enable(clkoutEnable),
        .divCode(clkoutDivider),
        .passThru(clkOutPassThru),
        .clkLevel_q(clkOutLevel),
        .clkEdge_q(clkOutRise)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Receive checks: one verdict pulse in the cycle after each valid strobe.

    rptcfg_addr_filter uAddrFilter (
        .filterMode(addressFilterMode),
        .nodeAddr(nodeAddr_q),
        .rxAddr(rxAddr),
        .accept(addrOk)
    );

    always @(posedge clock) begin
        if (!rst_n) begin
            rxAddrAccept_q <= 1'b0;
            rxAddrReject_q <= 1'b0;
            rxLengthAccept_q <= 1'b0;
            rxLengthReject_q <= 1'b0;
        end else begin
            rxAddrAccept_q <= rxAddrValid && addrOk;
            rxAddrReject_q <= rxAddrValid && !addrOk;
            if (rxLengthValid) begin
                rxLengthAccept_q <= lengthAllowed(lengthFormatSelect, rxLength,
                    payloadLength);
                rxLengthReject_q <= !lengthAllowed(lengthFormatSelect, rxLength,
                    payloadLength);
            end else begin
                rxLengthAccept_q <= 1'b0;
                rxLengthReject_q <= 1'b0;
            end
        end
    end

endmodule // rptcfg_bank

/* rptcfg_bank_props.sv */
// Concurrent checks on the ports of the packet and clock settings register bank.
module rptcfg_bank_props (
    input logic clock,
    input logic rst_n,
    input logic [7:0] regAddr,
    input logic [7:0] regWrData,
    input logic regWrite,
    input logic regRead,
    input logic [7:0] regRdData_q,
    input logic [7:0] rxAddr,
    input logic rxAddrValid,
    input logic [7:0] syncWordValue,
    input logic [3:0] txInterpCutoff,
    input logic [2:0] txPowerLevel,
    input logic clkoutEnable,
    input logic [4:0] clkoutDivider,
    input logic clkOutLevel,
    input logic clkOutPassThru,
    input logic manchesterEnable,
    input logic [6:0] payloadLength,
    input logic lengthFormatSelect,
    input logic txLengthFromReg_q,
    input logic [6:0] txLength_q,
    input logic [7:0] nodeLocalAddress,
    input logic [1:0] addressFilterMode,
    input logic rxAddrAccept_q,
    input logic rxAddrReject_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic addrOk;
    assign addrOk = (addressFilterMode == 2'h0) || (rxAddr == nodeLocalAddress)
        || (addressFilterMode[1] && rxAddr == 8'h00)
        || (addressFilterMode == 2'h3 && rxAddr == 8'hFF);
    ////////////////////////////////////////////////////////////////////////////
    a_sync_write: assert property (regWrite && regAddr == 8'h19 |=>
        syncWordValue == $past(regWrData)) else $error("sync byte write lost");
    a_txpar_write: assert property (regWrite && regAddr == 8'h1A |=>
        {txInterpCutoff, txPowerLevel} == $past(regWrData[7:1]))
        else $error("transmit fields wrong after write");
    a_clk_write: assert property (regWrite && regAddr == 8'h1B |=>
        {clkoutEnable, clkoutDivider} == $past(regWrData[7:2]))
        else $error("clock output fields wrong after write");
    a_pload_write: assert property (regWrite && regAddr == 8'h1C |=>
        {manchesterEnable, payloadLength} == $past(regWrData))
        else $error("payload fields wrong after write");
    a_node_write: assert property (regWrite && regAddr == 8'h1D |=>
        nodeLocalAddress == $past(regWrData)) else $error("node address write lost");
    a_pass_thru: assert property (clkOutPassThru == (clkoutEnable && clkoutDivider == 5'h00))
        else $error("pass-through level wrong");
    a_clk_silent: assert property (!clkoutEnable [*2] |=> !clkOutLevel)
        else $error("clock output moves while disabled");
    a_fixed_len: assert property (!lengthFormatSelect |=>
        txLengthFromReg_q && txLength_q == $past(payloadLength))
        else $error("fixed format transmit length wrong");
    a_var_len: assert property (lengthFormatSelect |=>
        !txLengthFromReg_q && txLength_q == 7'h00) else $error("variable format length used");
    a_addr_verdict: assert property (rxAddrValid |=>
        rxAddrAccept_q == $past(addrOk) && rxAddrReject_q == !$past(addrOk))
        else $error("address verdict wrong");
    a_read_idle: assert property (!regRead |=> regRdData_q == 8'h00)
        else $error("read data outside its cycle");
endmodule // rptcfg_bank_props

bind rptcfg_bank rptcfg_bank_props rptcfg_bank_props_i (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData_q(regRdData_q), .rxAddr(rxAddr), .rxAddrValid(rxAddrValid),
    .syncWordValue(syncWordValue), .txInterpCutoff(txInterpCutoff),
    .txPowerLevel(txPowerLevel), .clkoutEnable(clkoutEnable), .clkoutDivider(clkoutDivider),
    .clkOutLevel(clkOutLevel), .clkOutPassThru(clkOutPassThru),
    .manchesterEnable(manchesterEnable), .payloadLength(payloadLength),
    .lengthFormatSelect(lengthFormatSelect), .txLengthFromReg_q(txLengthFromReg_q),
    .txLength_q(txLength_q), .nodeLocalAddress(nodeLocalAddress),
    .addressFilterMode(addressFilterMode), .rxAddrAccept_q(rxAddrAccept_q),
    .rxAddrReject_q(rxAddrReject_q));

/* tb_top.sv */
// Self-checking bench for the packet and clock settings register bank.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rxAddr = 8'h00, rxLength = 8'h00;
    logic regWrite = 1'b0, regRead = 1'b0, rxAddrValid = 1'b0, rxLengthValid = 1'b0;
    logic [7:0] rdData;
    logic [15:0] cutoffKhz;
    logic [2:0] power;
    logic [6:0] txLen;
    logic clkPass, clkRise, clkLevel, manch, fromReg, aAcc, aRej, lAcc, lRej;
    int fails = 0, n_compared = 0;
    logic [7:0] addrs [7] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h20, 8'h21};
    logic [7:0] rstv [7] = '{8'h00, 8'h7C, 8'hBC, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ones [7] = '{8'hFF, 8'hFE, 8'hFC, 8'hFF, 8'hFF, 8'h86, 8'h00};
    logic [7:0] rxv [4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
    logic [15:0] accTab = 16'h731F;
    int nTab [3] = '{1, 3, 31};

    always #2 clock = ~clock;

    rptcfg_bank rptcfg_bank_i (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData_q(rdData),
        .rxAddr(rxAddr), .rxAddrValid(rxAddrValid), .rxLength(rxLength),
        .rxLengthValid(rxLengthValid), .syncWordValue(), .txInterpCutoff(),
        .txCutoffKhz_q(cutoffKhz), .txPowerLevel(power), .clkoutEnable(), .clkoutDivider(),
        .clkOutLevel(clkLevel), .clkOutRise(clkRise), .clkOutPassThru(clkPass),
        .manchesterEnable(manch), .payloadLength(), .lengthFormatSelect(),
        .txLengthFromReg_q(fromReg), .txLength_q(txLen), .nodeLocalAddress(),
        .addressFilterMode(), .rxAddrAccept_q(aAcc), .rxAddrReject_q(aRej),
        .rxLengthAccept_q(lAcc), .rxLengthReject_q(lRej));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1 chk(rdData, exp);
    endtask

    // Both verdict strobes share one task; the answer is looked at in its only cycle.
    task automatic rxq(input bit isLen, input logic [7:0] v, input bit exp);
        @(posedge clock);
        if (isLen) begin
            rxLengthValid <= 1'b1;
            rxLength <= v;
        end else begin
            rxAddrValid <= 1'b1;
            rxAddr <= v;
        end
        @(posedge clock);
        rxLengthValid <= 1'b0;
        rxAddrValid <= 1'b0;
        #1 chk(isLen ? {lAcc, lRej} : {aAcc, aRej}, {exp, !exp});
    endtask

    // Measures the distance between two rising pulses, skipping the settling period.
    task automatic period(input int n);
        int c;
        c = 0;
        // Let the edge that took the new code settle before looking at the pulse.
        #1;
        while (clkRise !== 1'b1 && c < 200) begin
            @(posedge clock);
            #1 c++;
        end
        c = 0;
        do begin
            @(posedge clock);
            #1 c++;
        end while (clkRise !== 1'b1 && c < 200);
        chk(16'(c), 16'(2 * n));
    endtask

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(addrs[i], rstv[i]);
        chk(cutoffKhz, 16'h00C8);
        chk(power, 3'h6);
        $display("reset values test done");
        // Software keeps the reserved low bit of the transmit register at zero.
        for (int i = 0; i < 7; i++) wr(addrs[i], (i == 1) ? 8'hFE : 8'hFF);
        for (int i = 0; i < 7; i++) rd(addrs[i], ones[i]);
        chk(cutoffKhz, 16'h0190);
        chk(power, 3'h7);
        chk({fromReg, txLen}, 8'h00);
        $display("access test done");
        wr(8'h20, 8'h00);
        wr(8'h1C, 8'h85);
        @(posedge clock);
        #1 chk({manch, fromReg, txLen}, 9'h185);
        rxq(1'b1, 8'h05, 1'b1);
        rxq(1'b1, 8'h04, 1'b0);
        wr(8'h20, 8'h80);
        rxq(1'b1, 8'h04, 1'b1);
        rxq(1'b1, 8'h05, 1'b1);
        rxq(1'b1, 8'h06, 1'b0);
        chk({fromReg, txLen}, 8'h00);
        $display("length test done");
        wr(8'h1D, 8'h5A);
        for (int m = 0; m < 4; m++) begin
            wr(8'h20, 8'(m * 2));
            for (int j = 0; j < 4; j++) rxq(1'b0, rxv[j], accTab[m * 4 + j]);
        end
        $display("address filter test done");
        for (int k = 0; k < 3; k++) begin
            wr(8'h1B, {1'b1, 5'(nTab[k]), 2'b00});
            period(nTab[k]);
        end
        wr(8'h1B, 8'h80);
        #1 chk(clkPass, 1'b1);
        wr(8'h1B, 8'h0C);
        repeat (3) @(posedge clock);
        #1 chk({clkPass, clkLevel}, 2'b00);
        $display("clock output test done");
        wrap_up;
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        wrap_up;
    end
endmodule // tb_top
